// ---- rtl/eea_access.sv ----
/*
 * eea_access: shared array access, address pointers and arbitration.
 * Assumes a CPU register port (one cycle strobes), a program fetch port
 * and a calculation unit sequencer with start, active and decrement lines.
 */
// Notes on behaviour
// - four check bits stored with each byte
// - single-bit errors corrected on every read
// - at most one requester owns the array
// - below 8000H array is data via registers
// - above 7FFFH fetches come from the array
// - executing from array ignores first pointer/data writes
// - array writes only from code in ROM
// - corrected data feeds calculation unit bus
// - address high from register, low from pointer
// - calculation access blocks all CPU access
// - calculation idle on array lets CPU in
// - pointer write reloads, read returns counter
// - high byte resets 80H, three bits used
// - pointer is reload register plus counter
// - first pointer and counter reset to 00H
// - idle: counter follows register, no decrement
// - second pointer never addresses CPU accesses
// - start loads counter, then sequencer decrements
// - mid-calculation rewrite reaches counter once calculation goes idle
// - second pointer behaves like the first, but takes writes when executing from array
`timescale 1ns/1ps
module eea_access
#(
	parameter int DEPTH_P = 2048
)
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [15:0] cpu_pc_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_rvalid_o,
	input wire logic fetch_req_i,
	input wire logic [10:0] fetch_addr_i,
	output logic [7:0] fetch_data_o,
	output logic fetch_valid_o,
	output logic fetch_stall_o,
	input wire logic calc_start_i,
	input wire logic calc_active_i,
	input wire logic calc_sel_x_i,
	input wire logic calc_dec_a_i,
	input wire logic calc_dec_x_i,
	output logic [7:0] calc_data_o,
	output logic calc_valid_o,
	output logic [1:0] owner_o
);
	import eea_pkg::*;
	// refuse any array depth other than the 2048 that the eleven-bit address covers
	if (DEPTH_P != DEPTH)
	begin : g_bad_depth
		$error("array depth must be 2048");
	end
	eea_arr_if arr ();
	eea_array #(.DEPTH_P(DEPTH_P)) u_array (.mclk_i(mclk_i), .reset_i(reset_i), .bus(arr));

	// register and pointer state
	logic [7:0] high_address_byte, next_high_address_byte;
	logic [7:0] reload [2];
	logic [7:0] next_reload [2];
	logic [7:0] count [2];
	logic [7:0] next_count [2];
	logic [7:0] program_time_scaler, next_program_time_scaler;
	logic [7:0] array_operation_control, next_array_operation_control;
	logic [7:0] array_test_control, next_array_test_control;
	logic [7:0] sfr_rdata, next_sfr_rdata;
	logic sfr_rvalid, next_sfr_rvalid;
	logic [7:0] fetch_data, next_fetch_data;
	logic fetch_valid, next_fetch_valid;
	logic fetch_stall, next_fetch_stall;
	logic [7:0] calc_data, next_calc_data;
	logic calc_valid, next_calc_valid;
	eea_owner_e owner, next_owner;
	logic in_rom;
	logic data_wr;
	logic [7:0] dec [2];
	logic [7:0] low_byte;

	// code position decides data or program use of the array
	always_comb
	begin
		in_rom = (cpu_pc_i < PROG_SPACE_BASE);
		data_wr = sfr_wr_i && (sfr_addr_i == ARRAY_DATA_PORT_ADDR);
	end

	// per-pointer reload register and down counter
	generate
		for (genvar p = 0; p < 2; p++)
		begin : g_ptr
			logic [7:0] ptr_addr;
			assign ptr_addr = (p == 0) ? OPERAND_X_LOW_POINTER_ADDR + 8'h01
				: OPERAND_X_LOW_POINTER_ADDR;
			assign dec[p] = (p == 0) ? {7'h00, calc_dec_a_i} : {7'h00, calc_dec_x_i};
			always_comb
			begin
				next_reload[p] = reload[p];
				next_count[p] = count[p];
				// the first pointer write is dropped while running from the array
				if (sfr_wr_i && sfr_addr_i == ptr_addr && (in_rom || p == 1))
					next_reload[p] = sfr_wdata_i;
				if (calc_start_i)
					next_count[p] = reload[p];
				else if (calc_active_i)
					next_count[p] = count[p] - dec[p];
				else
					next_count[p] = reload[p];
			end
			always_ff @(posedge mclk_i)
			begin
				if (reset_i)
				begin
					reload[p] <= LOW_POINTER_RST;
					count[p] <= LOW_POINTER_RST;
				end
				else
				begin
					reload[p] <= next_reload[p];
					count[p] <= next_count[p];
				end
			end
		end
	endgenerate

	// arbitration, address forming and register file
	always_comb
	begin
		next_high_address_byte = high_address_byte;
		next_program_time_scaler = program_time_scaler;
		next_array_operation_control = array_operation_control;
		next_array_test_control = array_test_control;
		next_sfr_rdata = sfr_rdata;
		next_sfr_rvalid = 1'b0;
		next_fetch_data = fetch_data;
		next_fetch_valid = 1'b0;
		next_fetch_stall = 1'b0;
		next_calc_data = calc_data;
		next_calc_valid = 1'b0;
		next_owner = EEA_OWN_IDLE;
		arr.we = 1'b0;
		arr.wdata = sfr_wdata_i;
		low_byte = count[0];
		if (calc_active_i && calc_sel_x_i)
			low_byte = count[1];
		arr.addr = {high_address_byte[2:0], low_byte};
		if (sfr_wr_i && sfr_addr_i == HIGH_ADDRESS_BYTE_ADDR && in_rom)
			next_high_address_byte = sfr_wdata_i;
		if (sfr_wr_i && sfr_addr_i == PROGRAM_TIME_SCALER_ADDR)
			next_program_time_scaler = sfr_wdata_i;
		if (sfr_wr_i && sfr_addr_i == ARRAY_OPERATION_CONTROL_ADDR)
			next_array_operation_control = sfr_wdata_i;
		if (sfr_wr_i && sfr_addr_i == ARRAY_TEST_CONTROL_ADDR)
			next_array_test_control = sfr_wdata_i;
		if (calc_active_i)
		begin
			// calculation unit wins; cpu fetches stall, data-port writes are dropped
			next_owner = EEA_OWN_CALC;
			next_calc_data = arr.rdata;
			next_calc_valid = 1'b1;
			next_fetch_stall = fetch_req_i;
		end
		else if (fetch_req_i && !in_rom)
		begin
			// program use: opcode fetch straight from the array
			next_owner = EEA_OWN_CPU;
			arr.addr = fetch_addr_i;
			next_fetch_data = arr.rdata;
			next_fetch_valid = 1'b1;
		end
		else if (data_wr && in_rom)
		begin
			next_owner = EEA_OWN_CPU;
			arr.we = 1'b1;
		end
		else if (sfr_rd_i || fetch_req_i)
			next_owner = EEA_OWN_CPU;
		// register read port: pointers return the counters
		if (sfr_rd_i)
		begin
			next_sfr_rvalid = 1'b1;
			if (sfr_addr_i == OPERAND_X_LOW_POINTER_ADDR)
				next_sfr_rdata = count[1];
			else if (sfr_addr_i == LOW_ADDRESS_POINTER_ADDR)
				next_sfr_rdata = count[0];
			else if (sfr_addr_i == HIGH_ADDRESS_BYTE_ADDR)
				next_sfr_rdata = high_address_byte;
			else if (sfr_addr_i == ARRAY_DATA_PORT_ADDR)
				next_sfr_rdata = calc_active_i ? 8'h00 : arr.rdata;
			else if (sfr_addr_i == PROGRAM_TIME_SCALER_ADDR)
				next_sfr_rdata = program_time_scaler;
			else if (sfr_addr_i == ARRAY_OPERATION_CONTROL_ADDR)
				next_sfr_rdata = array_operation_control;
			else if (sfr_addr_i == ARRAY_TEST_CONTROL_ADDR)
				next_sfr_rdata = array_test_control;
			else
				next_sfr_rdata = 8'h00;
		end
	end

	// register everything; outputs come from these flops
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			high_address_byte <= HIGH_ADDRESS_BYTE_RST;
			program_time_scaler <= TIME_SCALER_RST;
			array_operation_control <= CTRL_RST;
			array_test_control <= CTRL_RST;
			sfr_rdata <= 8'h00;
			sfr_rvalid <= 1'b0;
			fetch_data <= 8'h00;
			fetch_valid <= 1'b0;
			fetch_stall <= 1'b0;
			calc_data <= 8'h00;
			calc_valid <= 1'b0;
			owner <= EEA_OWN_IDLE;
		end
		else
		begin
			high_address_byte <= next_high_address_byte;
			program_time_scaler <= next_program_time_scaler;
			array_operation_control <= next_array_operation_control;
			array_test_control <= next_array_test_control;
			sfr_rdata <= next_sfr_rdata;
			sfr_rvalid <= next_sfr_rvalid;
			fetch_data <= next_fetch_data;
			fetch_valid <= next_fetch_valid;
			fetch_stall <= next_fetch_stall;
			calc_data <= next_calc_data;
			calc_valid <= next_calc_valid;
			owner <= next_owner;
		end
	end

	// output wiring from flops
	assign sfr_rdata_o = sfr_rdata;
	assign sfr_rvalid_o = sfr_rvalid;
	assign fetch_data_o = fetch_data;
	assign fetch_valid_o = fetch_valid;
	assign fetch_stall_o = fetch_stall;
	assign calc_data_o = calc_data;
	assign calc_valid_o = calc_valid;
	assign owner_o = owner;
endmodule : eea_access

// ---- common/eea_pkg.sv ----
/*
 * eea_pkg: register offsets, reset values and widths for the array access block.
 * Assumes an 8-bit special function register space addressed by byte.
 */
package eea_pkg;
	localparam logic [7:0] OPERAND_X_LOW_POINTER_ADDR = 8'hF1;
	localparam logic [7:0] LOW_ADDRESS_POINTER_ADDR = 8'hF2;
	localparam logic [7:0] HIGH_ADDRESS_BYTE_ADDR = 8'hF3;
	localparam logic [7:0] ARRAY_DATA_PORT_ADDR = 8'hF4;
	localparam logic [7:0] PROGRAM_TIME_SCALER_ADDR = 8'hF5;
	localparam logic [7:0] ARRAY_OPERATION_CONTROL_ADDR = 8'hF6;
	localparam logic [7:0] ARRAY_TEST_CONTROL_ADDR = 8'hF7;
	localparam logic [7:0] HIGH_ADDRESS_BYTE_RST = 8'h80;
	localparam logic [7:0] LOW_POINTER_RST = 8'h00;
	localparam logic [7:0] TIME_SCALER_RST = 8'h08;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] PROG_SPACE_BASE = 16'h8000;
	localparam int DATA_W = 8;
	localparam int CHECK_W = 4;
	localparam int WORD_W = 12;
	localparam int ADDR_W = 11;
	localparam int DEPTH = 2048;
	typedef enum logic [1:0] {
		EEA_OWN_IDLE = 2'b00,
		EEA_OWN_CPU = 2'b01,
		EEA_OWN_CALC = 2'b11
	} eea_owner_e;
endpackage : eea_pkg

// ---- common/eea_arr_if.sv ----
/*
 * eea_arr_if: port bundle between the access logic and the check-bit array.
 * Assumes one clock shared by both sides.
 */
`timescale 1ns/1ps
interface eea_arr_if;
	logic [10:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface : eea_arr_if

// ---- rtl/eea_code.sv ----
/*
 * eea_code: check-bit encoder and single-error corrector for one byte.
 * Assumes a twelve-bit stored word: data in the low byte, checks above.
 */
`timescale 1ns/1ps
module eea_code
(
	input wire logic [7:0] data_i,
	output logic [3:0] check_o,
	input wire logic [11:0] word_i,
	output logic [7:0] fixed_o
);
	import eea_pkg::*;
	// hamming position of each data bit inside the twelve-bit codeword
	function automatic logic [3:0] pos(input int i);
		logic [3:0] p [8];
		p = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};
		return p[i];
	endfunction : pos
	logic [3:0] syn;
	logic [3:0] chk_rd;
	// encode and correct: syndrome points at the flipped data bit
	always_comb
	begin
		check_o = 4'h0;
		chk_rd = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (data_i[i])
				check_o = check_o ^ pos(i);
			if (word_i[i])
				chk_rd = chk_rd ^ pos(i);
		end
		syn = chk_rd ^ word_i[11:8];
		fixed_o = word_i[7:0];
		for (int i = 0; i < 8; i++)
		begin
			if (syn == pos(i))
				fixed_o[i] = ~word_i[i];
		end
	end
endmodule : eea_code

// ---- rtl/eea_array.sv ----
/*
 * eea_array: flip-flop storage of data plus check bits, with corrected read.
 * Assumes writes are already qualified by the access logic.
 */
`timescale 1ns/1ps
module eea_array
#(
	parameter int DEPTH_P = 2048
)
(
	input wire logic mclk_i,
	input wire logic reset_i,
	eea_arr_if.mem bus
);
	import eea_pkg::*;
	// refuse a depth that does not match the address width
	if (DEPTH_P != (1 << ADDR_W))
	begin : g_bad_depth
		$error("depth must match the address width");
	end
	logic [11:0] mem [DEPTH_P];
	logic [11:0] next_mem_word;
	logic [3:0] chk;
	logic [11:0] rd_word;
	eea_code u_code (.data_i(bus.wdata), .check_o(chk), .word_i(rd_word), .fixed_o(bus.rdata));
	// stored word: four check bits beside every byte
	always_comb
	begin
		next_mem_word = {chk, bus.wdata};
		rd_word = mem[bus.addr];
	end
	// write one location per cycle
	always_ff @(posedge mclk_i)
	begin
		if (bus.we)
			mem[bus.addr] <= next_mem_word;
	end
endmodule : eea_array

// ---- verif/eea_access_asserts.sv ----
/*
 * eea_access_asserts: port timing checks for the array access block.
 * Assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module eea_access_asserts
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [15:0] cpu_pc_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_rvalid_o,
	input wire logic fetch_req_i,
	input wire logic fetch_valid_o,
	input wire logic fetch_stall_o,
	input wire logic calc_start_i,
	input wire logic calc_active_i,
	input wire logic calc_valid_o,
	input wire logic [1:0] owner_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// pointer write from rom, then a read of it two cycles on
	sequence s_ptr_wr;
		sfr_wr_i && sfr_addr_i == 8'hF2 && cpu_pc_i < 16'h8000 && !calc_active_i;
	endsequence
	sequence s_ptr_rd;
		sfr_rd_i && sfr_addr_i == 8'hF2 && !calc_active_i && !calc_start_i;
	endsequence
	AST_PTR_FOLLOW: assert property (
		s_ptr_wr ##2 s_ptr_rd |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
		else $error("pointer read does not follow write");
	AST_RD_ANSWER: assert property (sfr_rd_i |=> sfr_rvalid_o)
		else $error("read not answered");
	AST_RD_QUIET: assert property (!sfr_rd_i |=> !sfr_rvalid_o)
		else $error("read valid without read");
	AST_FETCH_SERVE: assert property (
		fetch_req_i && cpu_pc_i >= 16'h8000 && !calc_active_i
		|=> fetch_valid_o && !fetch_stall_o && owner_o == 2'b01)
		else $error("array fetch not served");
	AST_FETCH_BLOCK: assert property (
		fetch_req_i && calc_active_i |=> fetch_stall_o && !fetch_valid_o)
		else $error("fetch not blocked during calc access");
	AST_CALC_DATA: assert property (calc_active_i |=> calc_valid_o)
		else $error("calc data not delivered");
	AST_CALC_OWNER: assert property (calc_active_i |=> owner_o == 2'b11)
		else $error("calc access without ownership");
	AST_ONE_OWNER: assert property (owner_o != 2'b10)
		else $error("invalid owner code");
	AST_IDLE_OWNER: assert property (
		!calc_active_i && !fetch_req_i && !sfr_rd_i && !sfr_wr_i |=> owner_o == 2'b00)
		else $error("owner held without a request");
endmodule : eea_access_asserts

// ---- verif/eea_calc_model.sv ----
/*
 * eea_calc_model: calculation unit sequencer standing at the calc port.
 * Assumes the access block's clock; run is called from the bench.
 */
`timescale 1ns/1ps
module eea_calc_model
(
	input wire logic mclk_i,
	input wire logic [7:0] calc_data_i,
	output logic calc_start_o,
	output logic calc_active_o,
	output logic calc_sel_x_o,
	output logic calc_dec_a_o,
	output logic calc_dec_x_o
);
	// idle sequencer at time zero
	initial
	begin
		calc_start_o = 1'b0;
		calc_active_o = 1'b0;
		calc_sel_x_o = 1'b0;
		calc_dec_a_o = 1'b0;
		calc_dec_x_o = 1'b0;
	end
	// start, n decrements, one last operand fetch, then release
	task automatic run(input logic sx, input int n, output logic [7:0] d);
		@(posedge mclk_i);
		calc_start_o <= 1'b1;
		calc_sel_x_o <= sx;
		@(posedge mclk_i);
		calc_start_o <= 1'b0;
		calc_active_o <= 1'b1;
		calc_dec_a_o <= !sx;
		calc_dec_x_o <= sx;
		repeat (n) @(posedge mclk_i);
		calc_dec_a_o <= 1'b0;
		calc_dec_x_o <= 1'b0;
		@(posedge mclk_i);
		calc_active_o <= 1'b0;
		calc_sel_x_o <= 1'b0;
		#1;
		d = calc_data_i;
	endtask : run
endmodule : eea_calc_model

// ---- verif/eea_access_addressing_bench.sv ----
/*
 * eea_access_addressing_bench: register, fetch and calc walks on the access block.
 * Assumes the array and check-bit logic live inside the access block.
 */
`timescale 1ns/1ps
module eeprom_access_addressing_bench;
	import eea_pkg::*;
	localparam logic [7:0] PA = LOW_ADDRESS_POINTER_ADDR;
	localparam logic [7:0] DP = ARRAY_DATA_PORT_ADDR;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [15:0] pc = 16'h0000;
	logic [7:0] sa = 8'h00, swd = 8'h00, srd, cd, fd, got;
	logic swr = 1'b0, srq = 1'b0, sv, frq = 1'b0, fv, fs, cs, ca, cx, da, dx, cv;
	logic [10:0] fa = 11'h000;
	logic [1:0] own;
	int n_fail = 0;
	int checked = 0;
	eea_access dut (.mclk_i(mclk_i), .reset_i(reset_i), .cpu_pc_i(pc), .sfr_addr_i(sa),
		.sfr_wdata_i(swd), .sfr_wr_i(swr), .sfr_rd_i(srq), .sfr_rdata_o(srd), .sfr_rvalid_o(sv),
		.fetch_req_i(frq), .fetch_addr_i(fa), .fetch_data_o(fd), .fetch_valid_o(fv),
		.fetch_stall_o(fs), .calc_start_i(cs), .calc_active_i(ca), .calc_sel_x_i(cx),
		.calc_dec_a_i(da), .calc_dec_x_i(dx), .calc_data_o(cd), .calc_valid_o(cv), .owner_o(own));
	eea_calc_model pm (.mclk_i(mclk_i), .calc_data_i(cd), .calc_start_o(cs),
		.calc_active_o(ca), .calc_sel_x_o(cx), .calc_dec_a_o(da), .calc_dec_x_o(dx));
	// free running clock
	always #5 mclk_i = ~mclk_i;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			n_fail++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		sa <= a;
		swd <= d;
		swr <= 1'b1;
		@(posedge mclk_i);
		swr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		sa <= a;
		srq <= 1'b1;
		@(posedge mclk_i);
		srq <= 1'b0;
		#1;
		chk("rvalid", 8'h01, {7'h00, sv});
		chk("rdata", e, srd);
	endtask : rd
	task automatic fe(input logic [10:0] a);
		@(posedge mclk_i);
		fa <= a;
		frq <= 1'b1;
		@(posedge mclk_i);
		frq <= 1'b0;
		#1;
	endtask : fe
	task automatic setpc(input logic [15:0] v);
		@(posedge mclk_i);
		pc <= v;
	endtask : setpc
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// hang guard
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		n_fail++;
		final_report();
	end
	// main sequence
	initial
	begin
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd(HIGH_ADDRESS_BYTE_ADDR, 8'h80);
		rd(PA, 8'h00);
		rd(PROGRAM_TIME_SCALER_ADDR, 8'h08);
		rd(8'hF0, 8'h00);
		$display("test reset values done");
		wr(HIGH_ADDRESS_BYTE_ADDR, 8'h03);
		wr(PA, 8'hFF);
		wr(DP, 8'h77);
		wr(PA, 8'h10);
		wr(DP, 8'h66);
		wr(PA, 8'h34);
		rd(PA, 8'h34);
		wr(DP, 8'hA5);
		rd(DP, 8'hA5);
		setpc(16'h8000);
		wr(PA, 8'h00);
		wr(DP, 8'h5A);
		fe(11'h334);
		chk("fetch valid", 8'h01, {7'h00, fv});
		chk("fetch data", 8'hA5, fd);
		setpc(16'h0000);
		rd(PA, 8'h34);
		rd(DP, 8'hA5);
		$display("test data and program space done");
		wr(PA, 8'h00);
		fork
			pm.run(1'b0, 1, got);
			begin
				repeat (2) @(posedge mclk_i);
				wr(PA, 8'h50);
			end
		join
		chk("calc first", 8'h77, got);
		rd(PA, 8'h50);
		wr(PA, 8'h34);
		wr(OPERAND_X_LOW_POINTER_ADDR, 8'h11);
		setpc(16'h8000);
		fork
			pm.run(1'b1, 1, got);
			begin
				repeat (2) @(posedge mclk_i);
				fe(11'h334);
				chk("fetch stall", 8'h01, {7'h00, fs});
				chk("fetch valid", 8'h00, {7'h00, fv});
			end
		join
		chk("calc second", 8'h66, got);
		setpc(16'h0000);
		rd(DP, 8'hA5);
		rd(OPERAND_X_LOW_POINTER_ADDR, 8'h11);
		$display("test calc walks done");
		final_report();
	end
endmodule : eeprom_access_addressing_bench
bind eea_access eea_access_asserts chk (.mclk_i(mclk_i), .reset_i(reset_i),
	.cpu_pc_i(cpu_pc_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
	.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
	.sfr_rvalid_o(sfr_rvalid_o), .fetch_req_i(fetch_req_i), .fetch_valid_o(fetch_valid_o),
	.fetch_stall_o(fetch_stall_o), .calc_start_i(calc_start_i),
	.calc_active_i(calc_active_i), .calc_valid_o(calc_valid_o), .owner_o(owner_o));
